// [verilog/shutdown_seq_defines.svh]
`ifndef SHUTDOWN_SEQ_DEFINES_SVH
`define SHUTDOWN_SEQ_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define REG_BIAS          8'h04
`define REG_MIDRAIL       8'h05
`define REG_PHONES_GAIN   8'h0e
`define REG_LINE_GAIN     8'h0f
`define REG_CONVERTER     8'h12
`define REG_CLOCK_EN      8'h16
`define REG_SERVO         8'h43
`define REG_PHONES_OUT    8'h5a
`define REG_LINE_OUT      8'h5e
`define REG_CHARGE_PUMP   8'h62
`define REG_SEQ_CTRL      8'h6f
`define REG_SEQ_STATUS    8'h70

// ****************************************
// Fields and reset values
// ****************************************
`define CTRL_START_BIT    8
`define CTRL_ABORT_BIT    9
`define CTRL_INDEX_MSB    6
`define STATUS_BUSY_BIT   0
`define REG_RESET_VALUE   16'h0000
`define SEQ_SHUTDOWN_CMD  16'h0119
`define SEQ_FIRST_INDEX   6'h19
`define SEQ_LAST_INDEX    6'h27

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS     100
`define WAIT_BASE_NS      500000
`define WAIT_UNIT_NS      62500
`define POR_MIN_NS        9500
`define POR_CYCLES        ((`POR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [verilog/shutdown_seq_pkg.sv]
package shutdown_seq_pkg;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_WRITE,
      SEQ_WAIT
   } seq_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [3:0] width;
      logic [3:0] start;
      logic [7:0] data;
      logic [3:0] delay;
      logic       end_of_program_flag;
   } seq_step_t;

   typedef struct packed {
      seq_state_t        state;
      logic [5:0]        idx;
      logic [31:0]       wait_cnt;
      logic [9:0][15:0]  regs;
      logic [15:0]       rdata;
      logic              busy;
      logic              por_hold;
      logic [7:0]        por_cnt;
      logic [6:0]        start_index;
   } core_state_t;

endpackage : shutdown_seq_pkg

// [verilog/shutdown_seq.sv]
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "shutdown_seq_defines.svh"

module shutdown_seq #(
   parameter int unsigned WAIT_BASE_CYCLES = (`WAIT_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int unsigned WAIT_UNIT_CYCLES = (`WAIT_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   input  wire logic        mclk_in,                        // 10 MHz clock
   input  wire logic        rst_in,                         // Sync reset, high
   input  wire logic        por_n_in,                       // Power-on reset, low
   input  wire logic [7:0]  addr_in,                        // Register address
   input  wire logic [15:0] wdata_in,                       // Write data
   input  wire logic        wr_in,                          // Write strobe
   input  wire logic        rd_in,                          // Read strobe
   output logic [15:0]      rdata_out,                      // Read data, next cycle
   output logic             sequencer_busy_flag_out,        // Program running
   output logic             por_active_out,                 // Reset hold active
   output logic             line_left_short_remove_out,     // Line L short removed
   output logic             line_right_short_remove_out,    // Line R short removed
   output logic             phones_left_short_remove_out,   // Phones L short removed
   output logic             phones_right_short_remove_out,  // Phones R short removed
   output logic             phones_left_output_stage_en_out,  // Phones L output stage
   output logic             phones_left_delayed_stage_en_out, // Phones L delayed stage
   output logic             phones_left_main_en_out,        // Phones L main
   output logic             phones_right_output_stage_en_out, // Phones R output stage
   output logic             phones_right_delayed_stage_en_out, // Phones R delayed stage
   output logic             phones_right_main_en_out,       // Phones R main
   output logic             line_left_output_stage_en_out,  // Line L output stage
   output logic             line_left_delayed_stage_en_out, // Line L delayed stage
   output logic             line_left_main_en_out,          // Line L main
   output logic             line_right_output_stage_en_out, // Line R output stage
   output logic             line_right_delayed_stage_en_out, // Line R delayed stage
   output logic             line_right_main_en_out,         // Line R main
   output logic [3:0]       offset_servo_en_out,            // Servo ch3..ch0
   output logic             charge_pump_en_out,             // Charge pump
   output logic             left_converter_en_out,          // Left converter
   output logic             right_converter_en_out,         // Right converter
   output logic             signal_proc_clock_en_out,       // Processing clock
   output logic             phones_left_gain_stage_en_out,  // Phones L gain
   output logic             phones_right_gain_stage_en_out, // Phones R gain
   output logic             line_left_gain_stage_en_out,    // Line L gain
   output logic             line_right_gain_stage_en_out,   // Line R gain
   output logic             bias_en_out,                    // Bias
   output logic             midrail_reference_en_out,       // Midrail reference
   output logic             midrail_buffer_en_out,          // Midrail buffer
   output logic [1:0]       midrail_divider_select_out      // Midrail divider
);

   // ****************************************
   // Constants
   // ****************************************
   localparam logic [7:0]  POR_CYCLES_C = 8'(`POR_CYCLES);
   localparam logic [3:0]  IDX_NONE     = 4'hf;
   localparam int unsigned IDX_BIAS     = 0;
   localparam int unsigned IDX_MIDRAIL  = 1;
   localparam int unsigned IDX_PH_GAIN  = 2;
   localparam int unsigned IDX_LN_GAIN  = 3;
   localparam int unsigned IDX_CONV     = 4;
   localparam int unsigned IDX_CLOCK    = 5;
   localparam int unsigned IDX_SERVO    = 6;
   localparam int unsigned IDX_PH_OUT   = 7;
   localparam int unsigned IDX_LN_OUT   = 8;
   localparam int unsigned IDX_CP       = 9;

   localparam shutdown_seq_pkg::core_state_t RESET_STATE = '{
      state:       shutdown_seq_pkg::SEQ_IDLE,
      idx:         6'h00,
      wait_cnt:    32'h0000_0000,
      regs:        {10{`REG_RESET_VALUE}},
      rdata:       16'h0000,
      busy:        1'b0,
      por_hold:    1'b1,
      por_cnt:     8'h00,
      start_index: 7'h00
   };

   // ****************************************
   // Helper functions
   // ****************************************
   function automatic logic [3:0] reg_index(input logic [7:0] a);
      case (a)
         `REG_BIAS:        reg_index = 4'(IDX_BIAS);
         `REG_MIDRAIL:     reg_index = 4'(IDX_MIDRAIL);
         `REG_PHONES_GAIN: reg_index = 4'(IDX_PH_GAIN);
         `REG_LINE_GAIN:   reg_index = 4'(IDX_LN_GAIN);
         `REG_CONVERTER:   reg_index = 4'(IDX_CONV);
         `REG_CLOCK_EN:    reg_index = 4'(IDX_CLOCK);
         `REG_SERVO:       reg_index = 4'(IDX_SERVO);
         `REG_PHONES_OUT:  reg_index = 4'(IDX_PH_OUT);
         `REG_LINE_OUT:    reg_index = 4'(IDX_LN_OUT);
         `REG_CHARGE_PUMP: reg_index = 4'(IDX_CP);
         default:          reg_index = IDX_NONE;
      endcase
   endfunction : reg_index

   // Stored shutdown program
   function automatic shutdown_seq_pkg::seq_step_t step_of(input logic [5:0] i);
      case (i)
         6'h19:   step_of = '{`REG_LINE_OUT,    4'h8, 4'h0, 8'h77, 4'h0, 1'b0};
         6'h1a:   step_of = '{`REG_PHONES_OUT,  4'h8, 4'h0, 8'h77, 4'h0, 1'b0};
         6'h1b:   step_of = '{`REG_PHONES_OUT,  4'h8, 4'h0, 8'h00, 4'h0, 1'b0};
         6'h1c:   step_of = '{`REG_LINE_OUT,    4'h8, 4'h0, 8'h00, 4'h0, 1'b0};
         6'h1d:   step_of = '{`REG_SERVO,       4'h4, 4'h0, 8'h00, 4'h0, 1'b0};
         6'h1e:   step_of = '{`REG_CHARGE_PUMP, 4'h1, 4'h0, 8'h00, 4'h0, 1'b0};
         6'h1f:   step_of = '{`REG_CONVERTER,   4'h2, 4'h2, 8'h00, 4'h0, 1'b0};
         6'h20:   step_of = '{`REG_CLOCK_EN,    4'h1, 4'h1, 8'h00, 4'h0, 1'b0};
         6'h21:   step_of = '{`REG_PHONES_GAIN, 4'h2, 4'h0, 8'h00, 4'h0, 1'b0};
         6'h22:   step_of = '{`REG_LINE_GAIN,   4'h2, 4'h0, 8'h00, 4'h0, 1'b0};
         6'h23:   step_of = '{`REG_BIAS,        4'h1, 4'h0, 8'h00, 4'h0, 1'b0};
         6'h24:   step_of = '{`REG_MIDRAIL,     4'h1, 4'h0, 8'h00, 4'hc, 1'b0};
         6'h25:   step_of = '{`REG_MIDRAIL,     4'h1, 4'h0, 8'h00, 4'h9, 1'b0};
         6'h26:   step_of = '{`REG_MIDRAIL,     4'h8, 4'h0, 8'h00, 4'h0, 1'b0};
         default: step_of = '{`REG_BIAS,        4'h2, 4'h0, 8'h00, 4'h0, 1'b1};
      endcase
   endfunction : step_of

   // Masked field write
   function automatic logic [15:0] apply_step(input logic [15:0]                cur,
                                              input shutdown_seq_pkg::seq_step_t s);
      logic [15:0] mask;
      logic [15:0] val;
      mask = 16'((16'h0001 << s.width) - 16'h0001) << s.start;
      val  = ({8'h00, s.data} << s.start) & mask;
      return (cur & ~mask) | val;
   endfunction : apply_step

   // Step wait in cycles, 0.5 ms plus 62.5 us times two to the code
   function automatic logic [31:0] wait_cycles(input logic [3:0] code);
      return 32'(WAIT_BASE_CYCLES) + (32'(WAIT_UNIT_CYCLES) << code);
   endfunction : wait_cycles

   // ****************************************
   // State
   // ****************************************
   shutdown_seq_pkg::core_state_t st_ff;
   shutdown_seq_pkg::core_state_t nxt_st;
   shutdown_seq_pkg::seq_step_t   cur_step;
   logic [3:0]                    wr_idx;
   logic [3:0]                    rd_idx;
   logic                          hard_reset;
   logic                          start_req;

   assign hard_reset = rst_in | ~por_n_in;
   assign cur_step   = step_of(st_ff.idx);
   assign wr_idx     = reg_index(addr_in);
   assign rd_idx     = reg_index(addr_in);
   assign start_req  = wr_in && !st_ff.por_hold && addr_in == `REG_SEQ_CTRL &&
                       wdata_in[`CTRL_START_BIT] && !wdata_in[`CTRL_ABORT_BIT] &&
                       wdata_in[5:0] >= `SEQ_FIRST_INDEX && wdata_in[5:0] <= `SEQ_LAST_INDEX &&
                       !wdata_in[`CTRL_INDEX_MSB];

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.rdata = 16'h0000;
      if (st_ff.por_hold) begin
         // Stretch reset; bus writes are dropped meanwhile
         nxt_st.por_cnt = st_ff.por_cnt + 8'h01;
         if (st_ff.por_cnt == POR_CYCLES_C - 8'h01) begin
            nxt_st.por_hold = 1'b0;
         end
      end else begin
         // Host register write
         if (wr_in && wr_idx != IDX_NONE) begin
            nxt_st.regs[wr_idx] = wdata_in;
         end
         if (wr_in && addr_in == `REG_SEQ_CTRL) begin
            nxt_st.start_index = wdata_in[`CTRL_INDEX_MSB:0];
         end
         // Sequencer
         case (st_ff.state)
            shutdown_seq_pkg::SEQ_IDLE: begin
               if (start_req) begin
                  nxt_st.idx   = wdata_in[5:0];
                  nxt_st.busy  = 1'b1;
                  nxt_st.state = shutdown_seq_pkg::SEQ_WRITE;
               end
            end
            shutdown_seq_pkg::SEQ_WRITE: begin
               // Sequencer field is applied on top of a host write in the same cycle
               nxt_st.regs[reg_index(cur_step.addr)] =
                  apply_step(nxt_st.regs[reg_index(cur_step.addr)], cur_step);
               if (cur_step.end_of_program_flag) begin
                  nxt_st.busy  = 1'b0;
                  nxt_st.state = shutdown_seq_pkg::SEQ_IDLE;
               end else begin
                  nxt_st.wait_cnt = wait_cycles(cur_step.delay) - 32'h0000_0001;
                  nxt_st.state    = shutdown_seq_pkg::SEQ_WAIT;
               end
            end
            shutdown_seq_pkg::SEQ_WAIT: begin
               if (st_ff.wait_cnt == 32'h0000_0000) begin
                  nxt_st.idx   = st_ff.idx + 6'h01;
                  nxt_st.state = shutdown_seq_pkg::SEQ_WRITE;
               end else begin
                  nxt_st.wait_cnt = st_ff.wait_cnt - 32'h0000_0001;
               end
            end
            default: begin
               nxt_st.busy  = 1'b0;
               nxt_st.state = shutdown_seq_pkg::SEQ_IDLE;
            end
         endcase
         // Abort stops the program at once
         if (wr_in && addr_in == `REG_SEQ_CTRL && wdata_in[`CTRL_ABORT_BIT]) begin
            nxt_st.busy  = 1'b0;
            nxt_st.state = shutdown_seq_pkg::SEQ_IDLE;
         end
      end
      // Register read, answered one cycle later
      if (rd_in) begin
         if (rd_idx != IDX_NONE) begin
            nxt_st.rdata = st_ff.regs[rd_idx];
         end else if (addr_in == `REG_SEQ_CTRL) begin
            nxt_st.rdata = {9'h000, st_ff.start_index};
         end else if (addr_in == `REG_SEQ_STATUS) begin
            nxt_st.rdata = {15'h0000, st_ff.busy};
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (hard_reset) begin
         st_ff <= RESET_STATE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign rdata_out                         = st_ff.rdata;
   assign sequencer_busy_flag_out           = st_ff.busy;
   assign por_active_out                    = st_ff.por_hold;
   assign phones_left_main_en_out           = st_ff.regs[IDX_PH_OUT][0];
   assign phones_left_delayed_stage_en_out  = st_ff.regs[IDX_PH_OUT][1];
   assign phones_left_output_stage_en_out   = st_ff.regs[IDX_PH_OUT][2];
   assign phones_left_short_remove_out      = st_ff.regs[IDX_PH_OUT][3];
   assign phones_right_main_en_out          = st_ff.regs[IDX_PH_OUT][4];
   assign phones_right_delayed_stage_en_out = st_ff.regs[IDX_PH_OUT][5];
   assign phones_right_output_stage_en_out  = st_ff.regs[IDX_PH_OUT][6];
   assign phones_right_short_remove_out     = st_ff.regs[IDX_PH_OUT][7];
   assign line_left_main_en_out             = st_ff.regs[IDX_LN_OUT][0];
   assign line_left_delayed_stage_en_out    = st_ff.regs[IDX_LN_OUT][1];
   assign line_left_output_stage_en_out     = st_ff.regs[IDX_LN_OUT][2];
   assign line_left_short_remove_out        = st_ff.regs[IDX_LN_OUT][3];
   assign line_right_main_en_out            = st_ff.regs[IDX_LN_OUT][4];
   assign line_right_delayed_stage_en_out   = st_ff.regs[IDX_LN_OUT][5];
   assign line_right_output_stage_en_out    = st_ff.regs[IDX_LN_OUT][6];
   assign line_right_short_remove_out       = st_ff.regs[IDX_LN_OUT][7];
   assign offset_servo_en_out               = st_ff.regs[IDX_SERVO][3:0];
   assign charge_pump_en_out                = st_ff.regs[IDX_CP][0];
   assign left_converter_en_out             = st_ff.regs[IDX_CONV][2];
   assign right_converter_en_out            = st_ff.regs[IDX_CONV][3];
   assign signal_proc_clock_en_out          = st_ff.regs[IDX_CLOCK][1];
   assign phones_left_gain_stage_en_out     = st_ff.regs[IDX_PH_GAIN][0];
   assign phones_right_gain_stage_en_out    = st_ff.regs[IDX_PH_GAIN][1];
   assign line_left_gain_stage_en_out       = st_ff.regs[IDX_LN_GAIN][0];
   assign line_right_gain_stage_en_out      = st_ff.regs[IDX_LN_GAIN][1];
   assign bias_en_out                       = st_ff.regs[IDX_BIAS][0];
   assign midrail_reference_en_out          = st_ff.regs[IDX_MIDRAIL][0];
   assign midrail_divider_select_out        = st_ff.regs[IDX_MIDRAIL][2:1];
   assign midrail_buffer_en_out             = st_ff.regs[IDX_MIDRAIL][6];

   // ****************************************
   // Checks
   // ****************************************
   // Cycle counters for the timing checks
   logic [31:0] wait_seen_ff;
   logic [7:0]  por_seen_ff;

   always_ff @(posedge mclk_in) begin
      if (hard_reset || st_ff.state != shutdown_seq_pkg::SEQ_WAIT) begin
         wait_seen_ff <= 32'h0000_0000;
      end else begin
         wait_seen_ff <= wait_seen_ff + 32'h0000_0001;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (hard_reset) begin
         por_seen_ff <= 8'h00;
      end else if (st_ff.por_hold) begin
         por_seen_ff <= por_seen_ff + 8'h01;
      end
   end

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (hard_reset);

   sequence seq_cmd_shutdown;
      wr_in && addr_in == `REG_SEQ_CTRL && wdata_in == `SEQ_SHUTDOWN_CMD &&
      !st_ff.por_hold && st_ff.state == shutdown_seq_pkg::SEQ_IDLE;
   endsequence

   sequence seq_first_step;
      st_ff.busy && st_ff.idx == `SEQ_FIRST_INDEX && st_ff.state == shutdown_seq_pkg::SEQ_WRITE;
   endsequence

   chk_shutdown_start: assert property (seq_cmd_shutdown |=> seq_first_step)
      else $error("Shutdown command did not start at index 25");

   chk_line_short_clear: assert property (
      st_ff.state == shutdown_seq_pkg::SEQ_WRITE && st_ff.idx == 6'h19 && !(wr_in && addr_in == `REG_SEQ_CTRL)
      |=> st_ff.regs[IDX_LN_OUT][7:0] == 8'h77 && st_ff.state == shutdown_seq_pkg::SEQ_WAIT)
      else $error("Step 25 did not write 77h to line outputs");

   chk_step_field: assert property (
      st_ff.state == shutdown_seq_pkg::SEQ_WRITE && !(wr_in && addr_in == `REG_SEQ_CTRL)
      |=> st_ff.regs[reg_index($past(cur_step.addr))] ==
          apply_step($past(wr_in && wr_idx == reg_index(cur_step.addr)) ? $past(wdata_in) :
                     $past(st_ff.regs[reg_index(cur_step.addr)]), $past(cur_step)))
      else $error("Sequencer step left wrong register value");

   chk_wait_length: assert property (
      st_ff.state == shutdown_seq_pkg::SEQ_WAIT && st_ff.wait_cnt == 32'h0000_0000
      |-> wait_seen_ff == 32'(WAIT_BASE_CYCLES) + (32'(WAIT_UNIT_CYCLES) << cur_step.delay) - 32'h1)
      else $error("Step wait length wrong");

   chk_midrail_long_wait: assert property (
      st_ff.state == shutdown_seq_pkg::SEQ_WRITE && st_ff.idx == 6'h24 && !(wr_in && addr_in == `REG_SEQ_CTRL)
      |=> st_ff.wait_cnt == 32'(WAIT_BASE_CYCLES) + (32'(WAIT_UNIT_CYCLES) << 12) - 32'h1 &&
          !st_ff.regs[IDX_MIDRAIL][0])
      else $error("Reference step 36 wait or value wrong");

   chk_end_idle: assert property (
      st_ff.state == shutdown_seq_pkg::SEQ_WRITE && st_ff.idx == `SEQ_LAST_INDEX
      |=> !st_ff.busy && st_ff.state == shutdown_seq_pkg::SEQ_IDLE && st_ff.regs[IDX_BIAS][1:0] == 2'b00)
      else $error("Final step did not end the program");

   chk_busy_running: assert property (
      st_ff.state != shutdown_seq_pkg::SEQ_IDLE |-> st_ff.busy)
      else $error("Busy low while program runs");

   chk_por_write_block: assert property (
      st_ff.por_hold |=> st_ff.regs == $past(st_ff.regs) && !st_ff.busy)
      else $error("Register changed during power-on reset");

   chk_por_length: assert property ($fell(st_ff.por_hold) |-> por_seen_ff == POR_CYCLES_C)
      else $error("Power-on reset hold too short");

   chk_por_defaults: assert property (
      $fell(st_ff.por_hold) |-> st_ff.regs == {10{`REG_RESET_VALUE}} && st_ff.state == shutdown_seq_pkg::SEQ_IDLE)
      else $error("Registers not at defaults after reset");

   // ****************************************
   // Bus and control checks
   // ****************************************
   sequence seq_map_read;
      rd_in && rd_idx != IDX_NONE;
   endsequence

   chk_read_data: assert property (seq_map_read |=> rdata_out == $past(st_ff.regs[rd_idx]))
      else $error("Read data does not match stored register");

   chk_read_idle: assert property (!rd_in |=> rdata_out == 16'h0000)
      else $error("Read data not zero outside a read");

   chk_status_read: assert property (
      rd_in && addr_in == `REG_SEQ_STATUS |=> rdata_out == {15'h0000, $past(st_ff.busy)})
      else $error("Status read does not show busy");

   chk_busy_rise: assert property ($rose(st_ff.busy) |-> $past(start_req))
      else $error("Busy rose without a start command");

   chk_idle_not_busy: assert property (
      st_ff.state == shutdown_seq_pkg::SEQ_IDLE |-> !st_ff.busy)
      else $error("Busy high while sequencer idle");

   chk_step_advance: assert property (
      st_ff.state == shutdown_seq_pkg::SEQ_WAIT && st_ff.wait_cnt == 32'h0000_0000 &&
      !(wr_in && addr_in == `REG_SEQ_CTRL)
      |=> st_ff.state == shutdown_seq_pkg::SEQ_WRITE && st_ff.idx == $past(st_ff.idx) + 6'h01)
      else $error("Sequencer did not advance after its wait");

   chk_abort_stop: assert property (
      wr_in && addr_in == `REG_SEQ_CTRL && wdata_in[`CTRL_ABORT_BIT]
      |=> !st_ff.busy && st_ff.state == shutdown_seq_pkg::SEQ_IDLE)
      else $error("Abort did not stop the sequencer");

endmodule : shutdown_seq

// [verif/host_model.sv]
`timescale 1ns/1ps

module host_model (
   input  wire logic        mclk_in,    // Bus clock
   input  wire logic [15:0] rdata_in,   // Read data
   output logic [7:0]       addr_out,   // Address
   output logic [15:0]      wdata_out,  // Write data
   output logic             wr_out,     // Write strobe
   output logic             rd_out      // Read strobe
);
   initial begin
      addr_out  = 8'h00;
      wdata_out = 16'h0000;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
   end

   // Released lines show the inverse, so stale values never look valid
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      addr_out  <= a;
      wdata_out <= d;
      wr_out    <= 1'b1;
      @(posedge mclk_in);
      wr_out    <= 1'b0;
      addr_out  <= ~a;
      wdata_out <= ~d;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge mclk_in);
      rd_out   <= 1'b0;
      addr_out <= ~a;
      #1 d = rdata_in;
   endtask : rd_reg
endmodule : host_model

// [verif/shutdown_seq_tb.sv]
`timescale 1ns/1ps

module shutdown_seq_tb;
   localparam int WB = 4;
   localparam int WU = 1;
   logic        mclk_in, rst_in, por_n_in, wr, rd;
   logic [7:0]  addr;
   logic [15:0] wdata, rdata, v;
   logic        busy, por_act, cp, bias, mbuf;
   logic [3:0]  servo;
   wire  [7:0]  ph, ln;
   wire  [9:0]  misc;
   int          n_mismatch, total_checks, pos, off, n;
   logic [7:0]  pa [10] = '{8'h5a, 8'h5e, 8'h43, 8'h62, 8'h12, 8'h16, 8'h0e, 8'h0f, 8'h04, 8'h05};
   logic [15:0] pv [10] = '{16'h01ff, 16'h01ff, 16'h00ff, 16'h0003, 16'h000f, 16'h0003, 16'h0007,
                            16'h0007, 16'h0007, 16'h0147};
   logic [7:0]  sa [15] = '{8'h5e, 8'h5a, 8'h5a, 8'h5e, 8'h43, 8'h62, 8'h12, 8'h16, 8'h0e, 8'h0f,
                            8'h04, 8'h05, 8'h05, 8'h05, 8'h04};
   logic [15:0] sv [15] = '{16'h0177, 16'h0177, 16'h0100, 16'h0100, 16'h00f0, 16'h0002, 16'h0003,
                            16'h0001, 16'h0004, 16'h0004, 16'h0006, 16'h0146, 16'h0146, 16'h0100, 16'h0004};

   host_model u_host (.mclk_in(mclk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
                      .wr_out(wr), .rd_out(rd));

   shutdown_seq #(.WAIT_BASE_CYCLES(WB), .WAIT_UNIT_CYCLES(WU)) u_dut (
      .mclk_in(mclk_in), .rst_in(rst_in), .por_n_in(por_n_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sequencer_busy_flag_out(busy), .por_active_out(por_act),
      .line_left_short_remove_out(ln[3]), .line_right_short_remove_out(ln[7]),
      .phones_left_short_remove_out(ph[3]), .phones_right_short_remove_out(ph[7]),
      .phones_left_output_stage_en_out(ph[2]), .phones_left_main_en_out(ph[0]),
      .phones_left_delayed_stage_en_out(ph[1]), .phones_right_output_stage_en_out(ph[6]),
      .phones_right_main_en_out(ph[4]), .phones_right_delayed_stage_en_out(ph[5]),
      .line_left_output_stage_en_out(ln[2]), .line_left_main_en_out(ln[0]),
      .line_left_delayed_stage_en_out(ln[1]), .line_right_output_stage_en_out(ln[6]),
      .line_right_main_en_out(ln[4]), .line_right_delayed_stage_en_out(ln[5]),
      .offset_servo_en_out(servo), .charge_pump_en_out(cp),
      .left_converter_en_out(misc[9]), .right_converter_en_out(misc[8]), .signal_proc_clock_en_out(misc[7]),
      .phones_left_gain_stage_en_out(misc[6]), .phones_right_gain_stage_en_out(misc[5]),
      .line_left_gain_stage_en_out(misc[4]), .line_right_gain_stage_en_out(misc[3]), .bias_en_out(bias),
      .midrail_reference_en_out(misc[2]), .midrail_buffer_en_out(mbuf), .midrail_divider_select_out(misc[1:0]));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end

   initial begin
      repeat (20000) @(posedge mclk_in);
      n_mismatch++;
      end_sim();
   end

   // ****************************************
   // Power-on hold, presets, shutdown run
   // ****************************************
   initial begin
      rst_in = 1'b1;
      por_n_in = 1'b0;
      repeat (12) @(posedge mclk_in);
      rst_in <= 1'b0;
      por_n_in <= 1'b1;
      u_host.wr_reg(8'h5a, 16'h00ff);
      n = 2;
      while (por_act !== 1'b0 && n < 300) begin
         @(negedge mclk_in);
         n++;
      end
      chk(16'(n), 16'h0060);
      u_host.rd_reg(8'h5a, v);
      chk(v, 16'h0000);
      for (int i = 0; i < 10; i++) u_host.wr_reg(pa[i], pv[i]);
      u_host.rd_reg(8'h80, v);
      chk(v, 16'h0000);
      chk({9'h0, cp, bias, mbuf, servo}, 16'h007f);
      chk({ph, ln}, 16'hffff);
      chk({6'h00, misc}, 16'h03ff);
      u_host.wr_reg(8'h6f, 16'h0119);
      pos = 0;
      off = 0;
      for (int i = 0; i < 15; i++) begin
         repeat (off + 1 - pos) @(posedge mclk_in);
         u_host.rd_reg(sa[i], v);
         pos = off + 3;
         chk(v, sv[i]);
         if (i < 14) chk({15'h0, busy}, 16'h0001);
         if (i == 1) chk({ph, ln}, 16'h7777);
         if (i == 3) chk({ph, ln}, 16'h0000);
         off += WB + (WU << ((i == 11) ? 12 : ((i == 12) ? 9 : 0))) + 1;
      end
      chk({15'h0, busy}, 16'h0000);
      chk({9'h0, cp, bias, mbuf, servo}, 16'h0000);
      chk({ph, ln}, 16'h0000);
      chk({6'h00, misc}, 16'h0000);
      u_host.rd_reg(8'h70, v);
      chk(v, 16'h0000);
      // Restart, then abort mid-run
      u_host.wr_reg(8'h6f, 16'h0119);
      u_host.rd_reg(8'h70, v);
      chk(v, 16'h0001);
      u_host.wr_reg(8'h6f, 16'h0200);
      u_host.rd_reg(8'h70, v);
      chk(v, 16'h0000);
      @(posedge mclk_in);
      por_n_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      por_n_in <= 1'b1;
      u_host.wr_reg(8'h43, 16'hffff);
      u_host.rd_reg(8'h43, v);
      chk(v, 16'h0000);
      end_sim();
   end
endmodule : shutdown_seq_tb
